/* File: hw/uprf_framer.sv */
// top: upstream maintenance report framer, words in, framed bytes out
`timescale 1ns/1ps
`default_nettype none
module uprf_framer
    import uprf_pkg::*;
#(
    parameter int PW_W = 4
)
(
    input  wire logic             ref_clk_i,
    input  wire logic             rstn_i,
    input  wire logic             start_i,
    input  wire logic [1:0]       kind_i,
    output logic                  busy_o,
    output logic                  refused_o,
    input  wire logic [1:0]       cfg_hdr_ver_i,
    input  wire logic [PW_W-1:0]  cfg_pw_probe_i,
    input  wire logic [PW_W-1:0]  cfg_pw_capture_i,
    input  wire logic [PW_W-1:0]  cfg_pw_eratio_i,
    input  wire logic [7:0]       cfg_te_sections_i,
    input  wire logic [7:0]       cfg_mer_sections_i,
    input  wire logic [31:0]      timing_err_i,
    input  wire logic [7:0]       eq_sets_i,
    input  wire logic             eq_suppress_i,
    input  wire logic             vendor_flag_i,
    input  wire logic [23:0]      vendor_id_i,
    input  wire logic [7:0]       vendor_len_i,
    input  wire logic             cap_probe_i,
    input  wire logic             cap_quiet_i,
    input  wire logic [7:0]       nsym_i,
    input  wire logic [31:0]      pmap_i,
    input  wire logic [31:0]      minislot_i,
    input  wire logic [7:0]       cp_code_i,
    input  wire logic [7:0]       rolloff_i,
    input  wire logic [15:0]      cp_offset_i,
    input  wire logic [63:0]      timestamp_i,
    input  wire logic             fft_large_i,
    input  wire logic [7:0]       eratio_sections_i,
    input  wire logic             pmap_eratio_bit_i,
    input  wire logic [15:0]      eratio_words_i,
    input  wire logic [31:0]      trailer_i,
    input  wire logic             in_valid_i,
    input  wire logic [31:0]      in_data_i,
    output logic                  in_ready_o,
    output logic                  out_valid_o,
    output logic [7:0]            out_data_o,
    input  wire logic             out_ready_i,
    output logic                  out_sos_o,
    output logic                  out_eos_o,
    output logic                  out_eou_o,
    output logic [1:0]            out_seg_o,
    output logic [PW_W-1:0]       out_pw_o
);
    typedef enum logic [1:0] {S_IDLE, S_ENTER, S_LOAD, S_SEND} uprf_state_t;

    uprf_state_t      state_ff;
    uprf_kind_t       kind_ff;
    uprf_fld_t        fld_ff;
    logic [20:0]      rep_ff;
    logic [7:0]       set_ff;
    logic [11:0]      lsc_ff;
    logic [11:0]      hsc_ff;
    logic             first_ff;
    logic [PW_W-1:0]  pw_ff;
    logic             refused_ff;
    logic [7:0]       vcnt_ff;
    logic             refuse;
    logic             accept;
    logic             ld;
    logic             taken;
    logic             rest;
    logic             seg_close;
    logic             strm;
    logic [3:0]       nb;
    logic [4:0]       nxt_f;
    logic [63:0]      fv;
    logic [20:0]      rep_calc;
    logic             cp_ok;
    logic [20:0]      cap_words;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);

    uprf_ser_if ser ();

    uprf_ser u_ser (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .s         (ser)
    );

    uprf_cpdec u_cpdec (
        .cp_code_i   (cp_code_i),
        .fft_large_i (fft_large_i),
        .nsym_i      (nsym_i),
        .cp_valid_o  (cp_ok),
        .cp_len_o    (),
        .words_o     (cap_words)
    );

    // start checks; a refused start leaves the framer idle
    always_comb
    begin
        refuse = 1'b1;
        case (kind_i)
            UPRF_PROBE:   refuse = vendor_flag_i && (vendor_len_i > VEND_LEN_MAX);
            UPRF_CAPTURE: refuse = !(cap_probe_i || cap_quiet_i) || !cp_ok || (nsym_i == 8'h00);
            UPRF_ERATIO:  refuse = !pmap_eratio_bit_i || (eratio_words_i == 16'h0000);
            default:      refuse = 1'b1;
        endcase
    end
    assign accept = start_i && (state_ff == S_IDLE) && !refuse;

    // field shape: byte count, stream-sourced flag and successor
    always_comb
    begin
        {nb, strm, nxt_f} = {NB_B8, 1'b0, F_END};
        unique case (fld_ff)
            F_TE:     {nb, strm, nxt_f} = {NB_B32, 1'b0, F_SECTE};
            F_SECTE:  {nb, strm, nxt_f} = {NB_B32, 1'b1, F_SECMER};
            F_SECMER: {nb, strm, nxt_f} = {NB_B8, 1'b1, F_EQB};
            F_EQB:    {nb, strm, nxt_f} = {NB_B32, 1'b1, F_EQC};
            F_EQC:    {nb, strm, nxt_f} = {NB_B32, 1'b1, F_EQB};
            F_VID:    {nb, strm, nxt_f} = {NB_B24, 1'b0, F_VLEN};
            F_VLEN:   {nb, strm, nxt_f} = {NB_B8, 1'b0, F_VDAT};
            F_VDAT:   {nb, strm, nxt_f} = {NB_B8, 1'b1, F_END};
            F_STATUS: {nb, strm, nxt_f} = {NB_B8, 1'b0, F_RSV};
            F_RSV:    {nb, strm, nxt_f} = {NB_B16, 1'b0, F_CNT};
            F_CNT:    {nb, strm, nxt_f} = {NB_B8, 1'b0, F_PMAP};
            F_PMAP:   {nb, strm, nxt_f} = {NB_B32, 1'b0, F_MINI};
            F_MINI:   {nb, strm, nxt_f} = {NB_B32, 1'b0, (kind_ff == UPRF_CAPTURE) ? F_CP : F_DATA};
            F_CP:     {nb, strm, nxt_f} = {NB_B8, 1'b0, F_ROLL};
            F_ROLL:   {nb, strm, nxt_f} = {NB_B8, 1'b0, F_CPOFF};
            F_CPOFF:  {nb, strm, nxt_f} = {NB_B16, 1'b0, F_TS};
            F_TS:     {nb, strm, nxt_f} = {NB_B64, 1'b0, F_DATA};
            F_DATA:   {nb, strm, nxt_f} = {NB_B32, 1'b1, (kind_ff == UPRF_CAPTURE) ? F_END : F_TRL};
            F_TRL:    {nb, strm, nxt_f} = {NB_B32, 1'b0, F_END};
            default:  {nb, strm, nxt_f} = {NB_B8, 1'b0, F_END};
        endcase
    end

    // field value; stream fields take the low bytes of the input word
    always_comb
    begin
        fv = {32'h0, in_data_i};
        unique case (fld_ff)
            F_TE:     fv = {32'h0, timing_err_i};
            F_VID:    fv = {40'h0, vendor_id_i};
            F_VLEN:   fv = {56'h0, vendor_len_i};
            F_STATUS: fv = {56'h0, cfg_hdr_ver_i, STATUS_RSV};
            F_RSV:    fv = 64'h0;
            F_CNT:    fv = {56'h0, (kind_ff == UPRF_CAPTURE) ? nsym_i : eratio_sections_i};
            F_PMAP:   fv = {32'h0, pmap_i};
            F_MINI:   fv = {32'h0, minislot_i};
            F_CP:     fv = {56'h0, cp_code_i};
            F_ROLL:   fv = {56'h0, rolloff_i};
            F_CPOFF:  fv = {48'h0, cp_offset_i};
            F_TS:     fv = timestamp_i;
            F_TRL:    fv = {32'h0, trailer_i};
            default:  fv = {32'h0, in_data_i};
        endcase
    end

    // repetition count of each field; zero skips the field entirely
    always_comb
    begin
        rep_calc = 21'h000001;
        unique case (fld_ff)
            F_SECTE:  rep_calc = {13'h0000, cfg_te_sections_i};
            F_SECMER: rep_calc = {13'h0000, cfg_mer_sections_i};
            F_EQB:    rep_calc = {20'h00000, set_ff != 8'h00};
            F_EQC:    rep_calc = {9'h000, 12'(hsc_ff - lsc_ff)} + 21'h000001;
            F_VID:    rep_calc = {20'h00000, vendor_flag_i};
            F_VLEN:   rep_calc = {20'h00000, vendor_flag_i};
            F_VDAT:   rep_calc = vendor_flag_i ? {13'h0000, vendor_len_i} : 21'h000000;
            F_DATA:   rep_calc = (kind_ff == UPRF_CAPTURE) ? cap_words : {5'h00, eratio_words_i};
            F_END:    rep_calc = 21'h000000;
            default:  rep_calc = 21'h000001;
        endcase
    end

    // does any probe-tail byte still follow the current field
    always_comb
    begin
        rest = 1'b1;
        unique case (fld_ff)
            F_TE:     rest = (cfg_te_sections_i != 8'h00) || (cfg_mer_sections_i != 8'h00)
                             || (set_ff != 8'h00) || vendor_flag_i;
            F_SECTE:  rest = (cfg_mer_sections_i != 8'h00) || (set_ff != 8'h00) || vendor_flag_i;
            F_SECMER: rest = (set_ff != 8'h00) || vendor_flag_i;
            F_EQC:    rest = (set_ff > 8'h01) || vendor_flag_i;
            F_VLEN:   rest = (vendor_len_i != 8'h00);
            F_VDAT:   rest = 1'b0;
            default:  rest = 1'b1;
        endcase
    end

    // segment boundaries: one unit never shares a segment with another
    assign seg_close = (fld_ff == F_TS) || (fld_ff == F_MINI && kind_ff == UPRF_ERATIO)
                       || (fld_ff == F_DATA) || (fld_ff == F_TRL) || (kind_ff == UPRF_PROBE && !rest);
    assign out_eos_o = ser.bvalid && ser.blast && (rep_ff == 21'h000001) && seg_close;
    assign out_eou_o = out_eos_o && ((fld_ff == F_TRL) || (kind_ff == UPRF_PROBE)
                       || (fld_ff == F_DATA && kind_ff == UPRF_CAPTURE));
    assign out_seg_o = (fld_ff == F_TRL) ? SEG_TRL
                     : (fld_ff == F_DATA || kind_ff == UPRF_PROBE) ? SEG_PAY : SEG_HDR;

    // handshakes; the serializer is idle whenever the framer is in load
    assign ld          = (state_ff == S_LOAD) && (!strm || in_valid_i);
    assign in_ready_o  = (state_ff == S_LOAD) && strm;
    assign ser.load    = ld;
    assign ser.value   = fv;
    assign ser.nbytes  = nb;
    assign ser.bready  = out_ready_i;
    assign taken       = ser.bvalid && out_ready_i;
    assign out_valid_o = ser.bvalid;
    assign out_data_o  = ser.bdata;
    assign out_sos_o   = ser.bvalid && first_ff;
    assign out_pw_o    = pw_ff;
    assign busy_o      = (state_ff != S_IDLE);
    assign refused_o   = refused_ff;

    // sequencer: enter a field, load it, send all its repetitions
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state_ff <= S_IDLE;
            kind_ff  <= UPRF_PROBE;
            fld_ff   <= F_END;
            rep_ff   <= 21'h000000;
            set_ff   <= 8'h00;
        end
        else
        begin
            unique case (state_ff)
                S_IDLE:
                begin
                    if (accept)
                    begin
                        state_ff <= S_ENTER;
                        kind_ff  <= uprf_kind_t'(kind_i);
                        fld_ff   <= (kind_i == UPRF_PROBE) ? F_TE : F_STATUS;
                        set_ff   <= eq_suppress_i ? 8'h00 : eq_sets_i;
                    end
                end
                S_ENTER:
                begin
                    rep_ff <= rep_calc;
                    if (fld_ff == F_END)
                        state_ff <= S_IDLE;
                    else if (rep_calc == 21'h000000)
                        fld_ff <= (fld_ff == F_EQB) ? F_VID : uprf_fld_t'(nxt_f);
                    else
                        state_ff <= S_LOAD;
                end
                S_LOAD:
                begin
                    if (ld)
                        state_ff <= S_SEND;
                end
                S_SEND:
                begin
                    if (taken && ser.blast)
                    begin
                        rep_ff   <= rep_ff - 21'h000001;
                        state_ff <= (rep_ff == 21'h000001) ? S_ENTER : S_LOAD;
                        if (rep_ff == 21'h000001)
                            fld_ff <= uprf_fld_t'(nxt_f);
                        if (rep_ff == 21'h000001 && fld_ff == F_EQC)
                            set_ff <= set_ff - 8'h01;
                    end
                end
            endcase
        end
    end

    // equalizer set bounds arrive as one word, lowest subcarrier first
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            lsc_ff <= 12'h000;
            hsc_ff <= 12'h000;
        end
        else if (ld && fld_ff == F_EQB)
        begin
            lsc_ff <= in_data_i[27:16];
            hsc_ff <= in_data_i[11:0];
        end
    end

    // segment-start marker: after unit start and after every segment end except the one that closes the unit
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            first_ff <= 1'b0;
        else if (accept || (taken && out_eos_o && !out_eou_o))
            first_ff <= 1'b1;
        else if (taken)
            first_ff <= 1'b0;
    end

    // pseudowire of the unit is fixed for its whole length
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            pw_ff <= '0;
        else if (accept)
            pw_ff <= (kind_i == UPRF_PROBE) ? cfg_pw_probe_i
                   : (kind_i == UPRF_CAPTURE) ? cfg_pw_capture_i : cfg_pw_eratio_i;
    end

    // refusal pulse; starts while busy are simply ignored
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            refused_ff <= 1'b0;
        else
            refused_ff <= start_i && (state_ff == S_IDLE) && refuse;
    end

    // vendor content byte count, read only by the checks below
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            vcnt_ff <= 8'h00;
        else if (accept)
            vcnt_ff <= 8'h00;
        else if (taken && fld_ff == F_VDAT)
            vcnt_ff <= vcnt_ff + 8'h01;
    end

    vend_len_a: assert property (
        (out_valid_o && fld_ff == F_VLEN) |-> (out_data_o <= VEND_LEN_MAX))
        else $error("vendor length above limit");
    vend_count_a: assert property (
        (taken && out_eou_o && kind_ff == UPRF_PROBE)
        |-> ((vcnt_ff + 8'(fld_ff == F_VDAT)) == (vendor_flag_i ? vendor_len_i : 8'h00)))
        else $error("vendor content length mismatch");
    te_first_a: assert property (
        ($rose(busy_o) && kind_ff == UPRF_PROBE) |-> ##2 (out_valid_o && fld_ff == F_TE && out_sos_o))
        else $error("probe tail does not open with timing error");
    status_ver_a: assert property (
        (out_valid_o && fld_ff == F_STATUS) |-> (out_data_o == {cfg_hdr_ver_i, STATUS_RSV}))
        else $error("status byte malformed");
    cap_gate_a: assert property (
        (start_i && !busy_o && kind_i == UPRF_CAPTURE && !cap_probe_i && !cap_quiet_i)
        |=> (refused_o && !busy_o))
        else $error("capture accepted outside probe or quiet");
    er_gate_a: assert property (
        (start_i && !busy_o && kind_i == UPRF_ERATIO && !pmap_eratio_bit_i) |=> (refused_o && !busy_o))
        else $error("error ratio accepted without map bit");
    cap_notrl_a: assert property (
        (out_valid_o && kind_ff == UPRF_CAPTURE) |-> (out_seg_o != SEG_TRL))
        else $error("capture unit carries a trailer");
    er_trl_a: assert property (
        (out_eou_o && kind_ff == UPRF_ERATIO) |-> (out_seg_o == SEG_TRL && fld_ff == F_TRL))
        else $error("error ratio unit ends without trailer");
    no_concat_a: assert property (
        (taken && out_eou_o) |=> (!out_valid_o [*2]))
        else $error("next unit joined the closing segment");
    cp_map_a: assert property (
        (cp_code_i == 8'h0B) |-> (u_cpdec.cp_len_o == 10'h280 && cp_ok))
        else $error("prefix code 11 not 640 samples");
    pay_words_a: assert property (
        (nsym_i == 8'h01 && !fft_large_i && cp_code_i == 8'h01) |-> (cap_words == 21'h000860))
        else $error("capture payload word count wrong");

    probe_vend_c: cover property (taken && out_eou_o && kind_ff == UPRF_PROBE && vcnt_ff != 8'h00);
    cap_done_c: cover property (taken && out_eou_o && kind_ff == UPRF_CAPTURE);
    er_done_c: cover property (taken && out_eou_o && kind_ff == UPRF_ERATIO);
endmodule : uprf_framer
`default_nettype wire

/* File: hw/uprf_pkg.sv */
// package: constants and types of the upstream report framer
`default_nettype none
package uprf_pkg;
    typedef enum logic [1:0] {UPRF_PROBE, UPRF_CAPTURE, UPRF_ERATIO} uprf_kind_t;
    // fields in emission order of each unit kind
    typedef enum logic [4:0] {F_TE, F_SECTE, F_SECMER, F_EQB, F_EQC, F_VID, F_VLEN, F_VDAT,
                              F_STATUS, F_RSV, F_CNT, F_PMAP, F_MINI, F_CP, F_ROLL, F_CPOFF,
                              F_TS, F_DATA, F_TRL, F_END} uprf_fld_t;
    localparam logic [1:0]  SEG_HDR      = 2'h0;
    localparam logic [1:0]  SEG_PAY      = 2'h1;
    localparam logic [1:0]  SEG_TRL      = 2'h2;
    localparam logic [7:0]  VEND_LEN_MAX = 8'h20;
    localparam logic [5:0]  STATUS_RSV   = 6'h00;
    localparam logic [3:0]  NB_B8        = 4'h1;
    localparam logic [3:0]  NB_B16       = 4'h2;
    localparam logic [3:0]  NB_B24       = 4'h3;
    localparam logic [3:0]  NB_B32       = 4'h4;
    localparam logic [3:0]  NB_B64       = 4'h8;
    localparam logic [12:0] FFT_SMALL    = 13'h0800;
    localparam logic [12:0] FFT_LARGE    = 13'h1000;
    localparam logic [7:0]  CP_CODE_MIN  = 8'h01;
    localparam logic [7:0]  CP_CODE_MAX  = 8'h0B;
    localparam logic [9:0]  UPRF_CP_SAMPLES [0:15] = '{10'h000, 10'h060, 10'h080, 10'h0A0, 10'h0C0, 10'h0E0,
        10'h100, 10'h120, 10'h140, 10'h180, 10'h200, 10'h280, 10'h000, 10'h000, 10'h000, 10'h000};
endpackage : uprf_pkg
`default_nettype wire

/* File: hw/uprf_ser_if.sv */
// interface: field loader to byte serializer
`timescale 1ns/1ps
`default_nettype none
interface uprf_ser_if;
    logic        load;
    logic [63:0] value;
    logic [3:0]  nbytes;
    logic        busy;
    logic        bvalid;
    logic [7:0]  bdata;
    logic        blast;
    logic        bready;
    modport master (output load, value, nbytes, bready, input busy, bvalid, bdata, blast);
    modport slave  (input load, value, nbytes, bready, output busy, bvalid, bdata, blast);
endinterface : uprf_ser_if
`default_nettype wire

/* File: hw/uprf_ser.sv */
// leaf: msb-first byte serializer for one header or payload field
`timescale 1ns/1ps
`default_nettype none
module uprf_ser
    import uprf_pkg::*;
(
    input  wire logic  ref_clk_i,
    input  wire logic  rstn_i,
    uprf_ser_if.slave  s
);
    logic [63:0] sh_ff;
    logic [3:0]  cnt_ff;

    // left-align the field so the top byte is always the one on offer
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            sh_ff  <= 64'h0;
            cnt_ff <= 4'h0;
        end
        else if (s.load && cnt_ff == 4'h0)
        begin
            sh_ff  <= s.value << (7'h40 - {s.nbytes, 3'h0});
            cnt_ff <= s.nbytes;
        end
        else if (cnt_ff != 4'h0 && s.bready)
        begin
            sh_ff  <= {sh_ff[55:0], 8'h00};
            cnt_ff <= cnt_ff - 4'h1;
        end
    end

    // loads while busy are ignored; the framer never issues them
    assign s.busy   = (cnt_ff != 4'h0);
    assign s.bvalid = s.busy;
    assign s.bdata  = sh_ff[63:56];
    assign s.blast  = (cnt_ff == 4'h1);

    msb_first_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (s.load && !s.busy && s.nbytes == NB_B32) |=> (s.bdata == $past(s.value[31:24]))
        ##1 (!$past(s.bready) || s.bdata == $past(s.value[23:16], 2)))
        else $error("field not sent msb first");
endmodule : uprf_ser
`default_nettype wire

/* File: hw/uprf_cpdec.sv */
// leaf: cyclic prefix code decode and capture payload word count
`timescale 1ns/1ps
`default_nettype none
module uprf_cpdec
    import uprf_pkg::*;
(
    input  wire logic [7:0]  cp_code_i,
    input  wire logic        fft_large_i,
    input  wire logic [7:0]  nsym_i,
    output logic             cp_valid_o,
    output logic [9:0]       cp_len_o,
    output logic [20:0]      words_o
);
    logic [12:0] span;

    // codes outside 1..11 have no defined prefix and are refused by the framer
    assign cp_valid_o = (cp_code_i >= CP_CODE_MIN) && (cp_code_i <= CP_CODE_MAX);
    assign cp_len_o   = cp_valid_o ? UPRF_CP_SAMPLES[cp_code_i[3:0]] : 10'h000;

    // one symbol is fft length plus prefix, one 32-bit word per sample
    assign span    = (fft_large_i ? FFT_LARGE : FFT_SMALL) + {3'h0, cp_len_o};
    assign words_o = {13'h0000, nsym_i} * {8'h00, span};
endmodule : uprf_cpdec
`default_nettype wire

/* File: dv/uprf_sink.sv */
// partner: core controller byte sink that stalls at random
`timescale 1ns/1ps
`default_nettype none
module uprf_sink (
    input  wire logic        ref_clk_i,
    input  wire logic        valid_i,
    input  wire logic [9:0]  byte_i,
    input  wire logic        eos_i,
    input  wire logic        eou_i,
    output logic             ready_o = 1'b0
);
    logic [11:0] q[$];
    // stalls make the framer hold a pending byte
    always @(negedge ref_clk_i) ready_o <= ($urandom % 8) != 0;
    // keep each accepted byte with its segment and end marks
    always @(posedge ref_clk_i) if (valid_i && ready_o) q.push_back({eos_i, eou_i, byte_i});
endmodule : uprf_sink
`default_nettype wire

/* File: dv/upstream_pnm_report_framer_tb.sv */
// testbench: upstream report framer against a stalling byte sink
`timescale 1ns/1ps
`default_nettype none
module upstream_pnm_report_framer_tb
    import uprf_pkg::*;
;
    logic rstn_i, start_i, busy_o, refused_o, eq_suppress_i, vendor_flag_i, cap_probe_i, cap_quiet_i;
    logic fft_large_i, pmap_eratio_bit_i, in_ready_o, out_valid_o, out_ready_i, out_sos_o;
    logic ref_clk_i = 1'b0, in_valid_i = 1'b0, tk = 1'b0, ns = 1'b1;
    logic out_eos_o, out_eou_o;
    logic [1:0] kind_i, cfg_hdr_ver_i, out_seg_o;
    logic [3:0] cfg_pw_probe_i, cfg_pw_capture_i, cfg_pw_eratio_i, out_pw_o, pw;
    logic [7:0] cfg_te_sections_i, cfg_mer_sections_i, eq_sets_i, vendor_len_i, nsym_i, cp_code_i, rolloff_i;
    logic [7:0] eratio_sections_i, out_data_o;
    logic [15:0] cp_offset_i, eratio_words_i;
    logic [23:0] vendor_id_i;
    logic [31:0] timing_err_i, pmap_i, minislot_i, trailer_i, in_data_i;
    logic [63:0] timestamp_i;
    logic [31:0] w[$];
    logic [9:0] e[$];
    int error_cnt = 0;
    int checks = 0;
    uprf_framer dut (.*);
    uprf_sink sink (.ref_clk_i(ref_clk_i), .valid_i(out_valid_o), .byte_i({out_seg_o, out_data_o}),
                    .eos_i(out_eos_o), .eou_i(out_eou_o), .ready_o(out_ready_i));
    initial forever #5 ref_clk_i = ~ref_clk_i;
    // log taken words; a new word is offered only once the last was taken
    always @(posedge ref_clk_i) tk <= in_valid_i && in_ready_o;
    always @(posedge ref_clk_i) if (in_valid_i && in_ready_o) w.push_back(in_data_i);
    // bounds stay three apart, so every coefficient set is four words long
    always @(negedge ref_clk_i) if (tk || !in_valid_i)
        {in_valid_i, in_data_i} <= {1'($urandom % 4 != 0), 32'(($urandom % 2048) * 32'h00010001 + 3)};
    always @(posedge ref_clk_i) if (out_valid_o) chk(out_pw_o === pw, "pseudowire");
    // a segment opens on the first byte of a unit and on the byte after each segment end
    always @(posedge ref_clk_i) if (out_valid_o && out_ready_i) chk(out_sos_o === ns, "segment start");
    always @(posedge ref_clk_i) if (out_valid_o && out_ready_i) ns <= out_eos_o;
    task automatic chk(input logic c, input string m);
        checks++;
        error_cnt += int'(c !== 1'b1);
        if (c !== 1'b1) $display("BAD %0t %s", $time, m);
    endtask : chk
    task automatic complete_run();
        if (error_cnt == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : complete_run
    task automatic put(input logic [63:0] v, input int n, input logic [1:0] s);
        for (int i = n - 1; i >= 0; i--) e.push_back({s, v[8*i+:8]});
    endtask : put
    task automatic build(input logic [1:0] k);
        logic [31:0] v;
        if (k == UPRF_PROBE)
        begin
            put(timing_err_i, 4, SEG_PAY);
            repeat (cfg_te_sections_i) put(w.pop_front(), 4, SEG_PAY);
            repeat (cfg_mer_sections_i) put(w.pop_front(), 1, SEG_PAY);
            repeat (eq_suppress_i ? 8'h00 : eq_sets_i)
            begin
                v = w.pop_front();
                put(v, 4, SEG_PAY);
                repeat (v[11:0] - v[27:16] + 12'h001) put(w.pop_front(), 4, SEG_PAY);
            end
            if (vendor_flag_i) put({vendor_id_i, vendor_len_i}, 4, SEG_PAY);
            if (vendor_flag_i) repeat (vendor_len_i) put(w.pop_front(), 1, SEG_PAY);
        end
        else if (k == UPRF_CAPTURE)
        begin
            put({cfg_hdr_ver_i, STATUS_RSV, 16'h0000, nsym_i, pmap_i}, 8, SEG_HDR);
            put({minislot_i, cp_code_i, rolloff_i, cp_offset_i}, 8, SEG_HDR);
            put(timestamp_i, 8, SEG_HDR);
            v = (cp_code_i < 8'h09) ? 64 + 32 * cp_code_i : 128 * cp_code_i - 768;
            chk(w.size() == nsym_i * ((fft_large_i ? 4096 : 2048) + v), "capture words");
            repeat (w.size()) put(w.pop_front(), 4, SEG_PAY);
        end
        else
        begin
            put({cfg_hdr_ver_i, STATUS_RSV, 16'h0000, eratio_sections_i, pmap_i}, 8, SEG_HDR);
            put(minislot_i, 4, SEG_HDR);
            repeat (eratio_words_i) put(w.pop_front(), 4, SEG_PAY);
            put(trailer_i, 4, SEG_TRL);
        end
    endtask : build
    // draw a fresh legal configuration; capture stays short to bound the run
    task automatic rnd();
        {timing_err_i, pmap_i, minislot_i, trailer_i} = {$urandom, $urandom, $urandom, $urandom};
        timestamp_i = {$urandom, $urandom};
        {vendor_id_i, rolloff_i} = $urandom;
        {cp_offset_i, cfg_pw_probe_i, cfg_pw_capture_i, cfg_pw_eratio_i} = 28'($urandom);
        {cfg_hdr_ver_i, eq_suppress_i, vendor_flag_i} = 4'($urandom);
        {cfg_te_sections_i, cfg_mer_sections_i, eq_sets_i, eratio_sections_i} = $urandom & 32'h03030303;
        {cap_probe_i, cap_quiet_i, pmap_eratio_bit_i, fft_large_i, nsym_i, cp_code_i} = {4'hE, 8'h01, 8'h01};
        vendor_len_i = 8'($urandom % 33);
        eratio_words_i = 16'(1 + $urandom % 8);
    endtask : rnd
    task automatic run(input logic [1:0] k, input logic ok);
        int t;
        pw = (k == 2'h0) ? cfg_pw_probe_i : (k == 2'h1) ? cfg_pw_capture_i : cfg_pw_eratio_i;
        {kind_i, start_i} = {k, 1'b1};
        @(negedge ref_clk_i);
        start_i = 1'b0;
        chk(busy_o === ok && refused_o === !ok, "start answer");
        for (t = 0; t < 40000 && busy_o !== 1'b0; t++) @(negedge ref_clk_i);
        chk(t < 40000, "unit hang");
        if (t == 40000) complete_run();
        e = {};
        if (ok) build(k);
        chk(sink.q.size() == e.size(), "byte count");
        foreach (e[i]) chk(sink.q[i] === {(i == e.size() - 1) || (e[i][9:8] !== e[i + 1][9:8]),
                           i == e.size() - 1, e[i]}, "unit byte");
        sink.q = {};
        w = {};
    endtask : run
    initial
    begin
        void'($urandom(32'h46e6fa92));
        rnd();
        {start_i, kind_i, rstn_i} = '0;
        repeat (3) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        chk(busy_o === 1'b0 && out_valid_o === 1'b0 && in_ready_o === 1'b0, "reset state");
        rstn_i = 1'b1;
        run(UPRF_CAPTURE, 1'b1);
        {cap_probe_i, cp_code_i, fft_large_i} = {1'b0, 8'h0B, 1'b1};
        run(UPRF_CAPTURE, 1'b1);
        cap_quiet_i = 1'b0;
        run(UPRF_CAPTURE, 1'b0);
        {cap_quiet_i, cp_code_i} = {1'b1, 8'h0C};
        run(UPRF_CAPTURE, 1'b0);
        repeat (6)
        begin
            rnd();
            run(UPRF_PROBE, 1'b1);
            run(UPRF_ERATIO, 1'b1);
        end
        {vendor_flag_i, vendor_len_i, pmap_eratio_bit_i} = {1'b1, 8'h21, 1'b0};
        run(UPRF_PROBE, 1'b0);
        run(UPRF_ERATIO, 1'b0);
        run(2'h3, 1'b0);
        complete_run();
    end
endmodule : upstream_pnm_report_framer_tb
`default_nettype wire
